//--- rtl/lss_sequencer.v
// sideband reset, supply-stable and link-stop sequencer with apb registers
`timescale 1ns/1ns
`include "lss_defs.vh"

// What the document requires
// RQ1 - supply loss or reset beats link-stop
// RQ2 - link-stop released before chain reset release
// RQ3 - system keeps sideband skew within budget
// RQ4 - gen3 reset skew relief needs stop margins
// RQ5 - gen1 relief needs stop bit-time lead
// RQ6 - hot-add enable tolerates any reset skew
// RQ7 - stop skew relief needs state settings
// RQ8 - unlimited stop skew under listed conditions
// RQ9 - tolerate 200us supply skew, else hot-add
// RQ10 - link-stop held 1us after both see; a stop entered from the hot-add state is not held
// RQ11 - gen3 frequency change holds stop 100us; a stop entered from the hot-add state is not held
// RQ12 - sample supply/reset, gen1 may pull low
// RQ13 - gen3 one link-stop driver, gen1 wired-or
// RQ14 - filter slow sideband inputs before use
// RQ15 - system overlaps supply/reset pulses
// RQ16 - bridge owns separate secondary pin pair
// RQ17 - forward primary pair down, never up
// RQ18 - secondary reset errors outstanding nonposted
// RQ19 - host bridge drives, samples, relays host reset; the pair is driven in gen1 only
// RQ20 - host enforces ordering of chain pair
// RQ21 - two-flop sync counted in published delay
module lss_sequencer (
    // clock and reset
    input wire sys_clk_i,
    input wire rst_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    output wire pready_o,
    output wire pslverr_o,
    output wire [31:0] prdata_o,
    // primary chain pins, open drain
    input wire supply_stable_in_i,
    output wire supply_stable_out_o,
    output wire supply_stable_oe_o,
    input wire chain_reset_n_i,
    output wire chain_reset_n_out_o,
    output wire chain_reset_n_oe_o,
    // link-stop and link-request pins
    input wire link_stop_n_i,
    output wire link_stop_n_out_o,
    output wire link_stop_n_oe_o,
    input wire link_request_n_i,
    output wire link_request_n_out_o,
    output wire link_request_n_oe_o,
    // host side reset and power-good
    input wire host_reset_i,
    input wire host_power_good_i,
    // secondary chain pair, driven only
    output wire sec_supply_stable_o,
    output wire sec_chain_reset_n_o,
    // outstanding nonposted request tracking
    input wire np_issue_i,
    input wire np_done_i,
    output wire np_error_o,
    // state towards the link core
    output wire link_reset_o,
    output wire link_stop_o,
    output wire hot_add_o
);
    // ----------------------------------------------------------------
    // state codes
    // ----------------------------------------------------------------
    localparam [2:0] ST_OFF = 3'h0;
    localparam [2:0] ST_RESET = 3'h1;
    localparam [2:0] ST_RUN = 3'h2;
    localparam [2:0] ST_STOP = 3'h3;
    localparam [2:0] ST_HOT = 3'h4;
    localparam [23:0] STOP_HOLD = `LSS_STOP_HOLD_CYC;
    localparam [23:0] STOP_G3 = `LSS_STOP_G3_CYC;
    localparam [23:0] SUPPLY_SKEW = `LSS_SUPPLY_SKEW_CYC;

    reg [31:0] ctrl_q;
    reg [31:0] train_q;
    reg [31:0] skew_q;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [23:0] supply_cnt_q;
    reg hot_add_q;
    reg skew_ok_q;
    reg [7:0] np_cnt_q;
    reg np_err_q;
    reg sec_rst_q;
    reg [31:0] rdata_q;
    wire supply_f;
    wire reset_n_f;
    wire stop_n_f;
    wire req_n_f;
    wire host_rst_f;
    wire host_pg_f;
    wire stop_busy;
    wire stop_seen;
    wire apb_wr;
    wire apb_rd;
    wire hit;
    wire gen3;
    wire sys_supply;
    wire sys_reset;
    wire chain_reset;
    wire stop_req;

    // ----------------------------------------------------------------
    // input filtering
    // ----------------------------------------------------------------
    // every slow pin crosses two flops then a debounce, adding a fixed
    // delay that belongs in the published synchronisation delay
    lss_sync_filter #(.DEB_CYC(`LSS_DEB_CYC), .RST_VAL(1'b0)) u_f_supply ( // see RQ14 see RQ21
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .pin_i(supply_stable_in_i),
        .level_o(supply_f)
    );
    lss_sync_filter #(.DEB_CYC(`LSS_DEB_CYC), .RST_VAL(1'b0)) u_f_reset ( // see RQ12
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .pin_i(chain_reset_n_i),
        .level_o(reset_n_f)
    );
    lss_sync_filter #(.DEB_CYC(`LSS_DEB_CYC), .RST_VAL(1'b1)) u_f_stop (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .pin_i(link_stop_n_i),
        .level_o(stop_n_f)
    );
    lss_sync_filter #(.DEB_CYC(`LSS_DEB_CYC), .RST_VAL(1'b1)) u_f_req (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .pin_i(link_request_n_i),
        .level_o(req_n_f)
    );
    lss_sync_filter #(.DEB_CYC(`LSS_DEB_CYC), .RST_VAL(1'b1)) u_f_hrst (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .pin_i(host_reset_i),
        .level_o(host_rst_f)
    );
    lss_sync_filter #(.DEB_CYC(`LSS_DEB_CYC), .RST_VAL(1'b0)) u_f_hpg (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .pin_i(host_power_good_i),
        .level_o(host_pg_f)
    );

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    assign apb_wr = psel_i & penable_i & pwrite_i;
    assign apb_rd = psel_i & ~pwrite_i;
    assign hit = (paddr_i == `LSS_CTRL_OFF) | (paddr_i == `LSS_STAT_OFF) |
                 (paddr_i == `LSS_TRAIN_OFF) | (paddr_i == `LSS_SKEW_OFF) |
                 (paddr_i == `LSS_NP_OFF) | (paddr_i == `LSS_ID_OFF);
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~hit;
    assign prdata_o = rdata_q;

    function [31:0] strb_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] strb;
        integer i;
        begin
            strb_merge = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    strb_merge[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctrl_q <= `LSS_CTRL_RESET_VAL;
            train_q <= `LSS_TRAIN_RESET_VAL;
        end else if (apb_wr) begin
            if (paddr_i == `LSS_CTRL_OFF) begin
                ctrl_q <= strb_merge(ctrl_q, pwdata_i, pstrb_i);
            end
            if (paddr_i == `LSS_TRAIN_OFF) begin
                train_q <= strb_merge(train_q, pwdata_i, pstrb_i);
            end
        end
    end

    // read data registered in the setup cycle, valid in the access cycle
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (apb_rd & ~penable_i) begin
            case (paddr_i)
                `LSS_CTRL_OFF: rdata_q <= ctrl_q;
                `LSS_TRAIN_OFF: rdata_q <= train_q;
                `LSS_STAT_OFF: rdata_q <= {21'h00000, state_q,
                    skew_ok_q, hot_add_q, link_stop_o, ~chain_reset,
                    req_n_f, stop_n_f, reset_n_f, supply_f};
                `LSS_SKEW_OFF: rdata_q <= skew_q;
                `LSS_NP_OFF: rdata_q <= {23'h00000, np_err_q, np_cnt_q};
                `LSS_ID_OFF: rdata_q <= `LSS_ID_VAL;
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // chain reset pair
    // ----------------------------------------------------------------
    assign gen3 = ctrl_q[`LSS_CTRL_GEN3];
    // host bridge relays host reset and power-good onto the chain pair in gen1 only
    assign sys_supply = supply_f & (~ctrl_q[`LSS_CTRL_HOSTB] | host_pg_f); // see RQ19
    assign sys_reset = ~reset_n_f | (ctrl_q[`LSS_CTRL_HOSTB] & host_rst_f); // see RQ19
    // supply loss or reset outranks any link-stop request
    assign chain_reset = ~sys_supply | sys_reset; // see RQ1

    // open-drain pulls low only; gen3 devices never drive the pair
    assign supply_stable_out_o = 1'b0;
    assign supply_stable_oe_o = ~gen3 & (ctrl_q[`LSS_CTRL_DRV_SUPPLY] |
        (ctrl_q[`LSS_CTRL_HOSTB] & ~host_pg_f)); // see RQ12 see RQ19
    assign chain_reset_n_out_o = 1'b0;
    assign chain_reset_n_oe_o = ~gen3 & (ctrl_q[`LSS_CTRL_DRV_RESET] |
        (ctrl_q[`LSS_CTRL_HOSTB] & (host_rst_f | ~host_pg_f))); // see RQ12 see RQ20

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    assign stop_req = ctrl_q[`LSS_CTRL_STOP_REQ] & ctrl_q[`LSS_CTRL_STOP_OWNER];
    assign stop_seen = ~stop_n_f;

    lss_hold_timer #(.WIDTH(24)) u_stop_hold ( // see RQ10 see RQ11
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .start_i((state_q == ST_RUN) & stop_seen),
        .load_i(gen3 ? STOP_G3 : STOP_HOLD),
        .busy_o(stop_busy)
    );

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (sys_supply) begin
                    state_d = ST_RESET;
                end
            end
            ST_RESET: begin
                // reset release is only honoured once link-stop is gone
                if (~sys_supply) begin
                    state_d = ST_OFF;
                end else if (~sys_reset & ~stop_seen) begin // see RQ2
                    state_d = skew_ok_q ? ST_RUN : ST_HOT; // see RQ9 see RQ6
                end
            end
            ST_RUN, ST_HOT: begin
                if (chain_reset) begin
                    state_d = sys_supply ? ST_RESET : ST_OFF; // see RQ1
                end else if (stop_seen) begin
                    state_d = ST_STOP;
                end
            end
            ST_STOP: begin
                if (chain_reset) begin
                    state_d = sys_supply ? ST_RESET : ST_OFF; // see RQ1
                end else if (~stop_seen & ~stop_busy) begin
                    state_d = ST_RUN;
                end
            end
            default: state_d = ST_OFF;
        endcase
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_q <= ST_OFF;
            supply_cnt_q <= 24'h000000;
            skew_ok_q <= 1'b1;
            hot_add_q <= 1'b0;
            skew_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            // time from supply good to reset release measures late arrival
            if (state_q == ST_OFF) begin
                supply_cnt_q <= 24'h000000;
                skew_ok_q <= 1'b1;
            end else if ((state_q == ST_RESET) && (supply_cnt_q != 24'hffffff)) begin
                supply_cnt_q <= supply_cnt_q + 24'h000001;
            end
            if ((state_q == ST_RESET) && (state_d != ST_RESET)) begin
                skew_q <= {8'h00, supply_cnt_q};
            end
            // late-seeing gen3 device is treated as hot-added when allowed
            if (state_q == ST_OFF) begin
                hot_add_q <= 1'b0;
            end else if ((state_q == ST_RESET) && (state_d == ST_HOT)) begin
                hot_add_q <= 1'b1; // see RQ9 see RQ6
            end
            if (state_q == ST_RESET) begin
                skew_ok_q <= ~gen3 | (supply_cnt_q < SUPPLY_SKEW) |
                    ~train_q[`LSS_TR_HOT_ADD]; // see RQ9
            end
        end
    end

    // ----------------------------------------------------------------
    // link-stop and link-request drive
    // ----------------------------------------------------------------
    // only the configured owner drives link-stop, and never during reset
    assign link_stop_n_out_o = 1'b0;
    assign link_stop_n_oe_o = stop_req & ~chain_reset; // see RQ13 see RQ2
    assign link_request_n_out_o = 1'b0;
    assign link_request_n_oe_o = ~gen3 & ctrl_q[`LSS_CTRL_LINKREQ]; // see RQ13

    assign link_reset_o = (state_q == ST_OFF) | (state_q == ST_RESET);
    assign link_stop_o = (state_q == ST_STOP);
    assign hot_add_o = hot_add_q;

    // ----------------------------------------------------------------
    // bridge forwarding and nonposted error return
    // ----------------------------------------------------------------
    // primary changes flow down only; nothing here reads secondary pins
    assign sec_supply_stable_o = ctrl_q[`LSS_CTRL_BRIDGE] ? sys_supply : 1'b0; // see RQ16 see RQ17
    assign sec_chain_reset_n_o = ctrl_q[`LSS_CTRL_BRIDGE] ? ~chain_reset : 1'b0; // see RQ17
    assign np_error_o = np_err_q;

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            np_cnt_q <= 8'h00;
            np_err_q <= 1'b0;
            sec_rst_q <= 1'b0;
        end else begin
            sec_rst_q <= chain_reset & ctrl_q[`LSS_CTRL_BRIDGE];
            np_err_q <= 1'b0;
            if (sec_rst_q & (np_cnt_q != 8'h00)) begin
                // one error response per cycle until the count drains
                np_err_q <= 1'b1; // see RQ18
                np_cnt_q <= np_cnt_q - 8'h01;
            end else if (np_issue_i & ~np_done_i & (np_cnt_q != 8'hff)) begin
                np_cnt_q <= np_cnt_q + 8'h01;
            end else if (~np_issue_i & np_done_i & (np_cnt_q != 8'h00)) begin
                np_cnt_q <= np_cnt_q - 8'h01;
            end
        end
    end
endmodule // lss_sequencer

//--- inc/lss_defs.vh
// constants for the sideband reset and link-stop sequencer
`ifndef LSS_DEFS_VH
`define LSS_DEFS_VH

// register byte offsets
`define LSS_CTRL_OFF 12'h000
`define LSS_STAT_OFF 12'h004
`define LSS_TRAIN_OFF 12'h008
`define LSS_SKEW_OFF 12'h00c
`define LSS_NP_OFF 12'h010
`define LSS_ID_OFF 12'h014

// ctrl fields
`define LSS_CTRL_DRV_SUPPLY 0
`define LSS_CTRL_DRV_RESET 1
`define LSS_CTRL_GEN3 2
`define LSS_CTRL_STOP_OWNER 3
`define LSS_CTRL_STOP_REQ 4
`define LSS_CTRL_LINKREQ 5
`define LSS_CTRL_BRIDGE 6
`define LSS_CTRL_HOSTB 7
`define LSS_CTRL_RESET_VAL 32'h0000_0003

// train fields
`define LSS_TR_HOT_ADD 0
`define LSS_TR_LS_EN 1
`define LSS_TR_RXSEL_LO 2
`define LSS_TR_TXSEL_LO 4
`define LSS_TR_DWELL_LO 8
`define LSS_TRAIN_RESET_VAL 32'h0000_0002

// status fields
`define LSS_ST_SUPPLY 0
`define LSS_ST_RESET_N 1
`define LSS_ST_STOP_N 2
`define LSS_ST_REQ_N 3
`define LSS_ST_CHAIN_UP 4
`define LSS_ST_STOP_ACT 5
`define LSS_ST_HOT_ADD 6
`define LSS_ST_SKEW_OK 7
`define LSS_ST_STATE_LO 8

// timing in ns and derived cycles at 50 MHz
`define LSS_CLK_NS 20
`define LSS_DEB_NS 200
`define LSS_DEB_CYC ((`LSS_DEB_NS + `LSS_CLK_NS - 1) / `LSS_CLK_NS)
`define LSS_STOP_HOLD_NS 1000
`define LSS_STOP_HOLD_CYC ((`LSS_STOP_HOLD_NS + `LSS_CLK_NS - 1) / `LSS_CLK_NS)
`define LSS_STOP_G3_NS 100000
`define LSS_STOP_G3_CYC ((`LSS_STOP_G3_NS + `LSS_CLK_NS - 1) / `LSS_CLK_NS)
`define LSS_SUPPLY_SKEW_NS 200000
`define LSS_SUPPLY_SKEW_CYC (`LSS_SUPPLY_SKEW_NS / `LSS_CLK_NS)
`define LSS_ID_VAL 32'h0000_5a01

`endif

//--- rtl/lss_sync_filter.v
// two-flop synchroniser followed by a debounce filter
`timescale 1ns/1ns
module lss_sync_filter #(
    parameter integer DEB_CYC = 10,
    parameter RST_VAL = 1'b0
) (
    // clock and reset
    input wire sys_clk_i,
    input wire rst_i,
    // pin and filtered level
    input wire pin_i,
    output wire level_o
);
    reg meta_q;
    reg sync_q;
    reg level_q;
    reg [7:0] cnt_q;

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
            level_q <= RST_VAL;
            cnt_q <= 8'h00;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            // slow edges bounce: accept a new level only once it stayed put
            if (sync_q == level_q) begin
                cnt_q <= 8'h00;
            end else if (cnt_q == DEB_CYC[7:0] - 8'h01) begin
                level_q <= sync_q;
                cnt_q <= 8'h00;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    assign level_o = level_q;
endmodule // lss_sync_filter

//--- rtl/lss_hold_timer.v
// down counter giving a minimum hold time after a start pulse
`timescale 1ns/1ns
module lss_hold_timer #(
    parameter integer WIDTH = 16
) (
    // clock and reset
    input wire sys_clk_i,
    input wire rst_i,
    // control
    input wire start_i,
    input wire [WIDTH-1:0] load_i,
    output wire busy_o
);
    reg [WIDTH-1:0] cnt_q;

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            cnt_q <= {WIDTH{1'b0}};
        end else if (start_i) begin
            cnt_q <= load_i;
        end else if (cnt_q != {WIDTH{1'b0}}) begin
            cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    assign busy_o = (cnt_q != {WIDTH{1'b0}});
endmodule // lss_hold_timer

//--- tb/lss_monitor.sv
// assertion checker for the sideband sequencer ports
`timescale 1ns/1ns
module lss_monitor (
    // clock and reset
    input wire sys_clk_i,
    input wire rst_i,
    // apb
    input wire psel_i,
    input wire penable_i,
    input wire pready_o,
    input wire pslverr_o,
    // chain pins
    input wire supply_stable_in_i,
    input wire chain_reset_n_i,
    input wire link_stop_n_i,
    input wire supply_stable_out_o,
    input wire chain_reset_n_out_o,
    input wire link_stop_n_out_o,
    input wire link_request_n_out_o,
    // state
    input wire sec_chain_reset_n_o,
    input wire np_error_o,
    input wire link_reset_o,
    input wire link_stop_o
);
    // one cycle of slack for the counter's own register stage
    localparam int HOLD_MIN = 49;
    int stop_cnt_q;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    always @(posedge sys_clk_i) begin
        if (rst_i || !link_stop_o) begin
            stop_cnt_q <= 0;
        end else begin
            stop_cnt_q <= stop_cnt_q + 1;
        end
    end
    ready_always_a: assert property (pready_o) else $error("pready low");
    err_in_access_a: assert property (pslverr_o |-> psel_i && penable_i)
        else $error("slave error outside access");
    open_drain_a: assert property (!supply_stable_out_o && !chain_reset_n_out_o
        && !link_stop_n_out_o && !link_request_n_out_o) else $error("pin driven high");
    reset_beats_stop_a: assert property (!(link_stop_o && link_reset_o))
        else $error("stop and reset together");
    supply_loss_a: assert property ((!supply_stable_in_i)[*8] ##1
        (!supply_stable_in_i)[*8] |-> ##[0:6] link_reset_o) else $error("supply loss ignored");
    chain_reset_a: assert property ((!chain_reset_n_i)[*8] ##1
        (!chain_reset_n_i)[*8] |-> ##[0:6] link_reset_o) else $error("chain reset ignored");
    stop_filtered_a: assert property ($rose(link_stop_o) |->
        !$past(link_stop_n_i, 4) && !$past(link_stop_n_i, 9)) else $error("stop unfiltered");
    stop_hold_a: assert property ($fell(link_stop_o) && !link_reset_o |->
        stop_cnt_q >= HOLD_MIN) else $error("stop left too early");
    np_err_reset_a: assert property (np_error_o |->
        !sec_chain_reset_n_o || !$past(sec_chain_reset_n_o)) else $error("error outside reset");
    cover property ($rose(link_stop_o));
    cover property (np_error_o);
    cover property (pslverr_o);
endmodule // lss_monitor

bind lss_sequencer lss_monitor u_lss_monitor (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .supply_stable_in_i(supply_stable_in_i), .chain_reset_n_i(chain_reset_n_i),
    .link_stop_n_i(link_stop_n_i), .supply_stable_out_o(supply_stable_out_o),
    .chain_reset_n_out_o(chain_reset_n_out_o), .link_stop_n_out_o(link_stop_n_out_o),
    .link_request_n_out_o(link_request_n_out_o), .sec_chain_reset_n_o(sec_chain_reset_n_o),
    .np_error_o(np_error_o), .link_reset_o(link_reset_o), .link_stop_o(link_stop_o));

//--- tb/lss_far_model.sv
// system reset controller and chain peers as seen on the sideband pins
`timescale 1ns/1ns
module lss_far_model (
    // clock
    input wire sys_clk_i,
    // wishes of the bench
    input wire supply_on_i,
    input wire reset_on_i,
    input wire stop_on_i,
    input wire req_on_i,
    // device pull-downs
    input wire supply_oe_i,
    input wire reset_oe_i,
    input wire stop_oe_i,
    input wire req_oe_i,
    // resolved pin levels
    output wire supply_o,
    output wire reset_n_o,
    output wire stop_n_o,
    output wire req_n_o
);
    reg rst_n_q = 1'b0;
    reg stop_q = 1'b0;
    integer hold_q = 0;
    always @(posedge sys_clk_i) begin
        // filter delay of both ends plus 1us
        stop_q <= stop_on_i || (stop_q && hold_q < 80);
        hold_q <= stop_q ? hold_q + 1 : 0;
        if (reset_on_i) begin
            rst_n_q <= 1'b0;
        end else if (!stop_q && !stop_on_i) begin
            rst_n_q <= 1'b1;
        end
    end
    // pull-ups win once every driver lets go
    assign supply_o = supply_on_i & ~supply_oe_i;
    assign reset_n_o = rst_n_q & ~reset_oe_i;
    assign stop_n_o = ~stop_q & ~stop_oe_i;
    assign req_n_o = ~req_on_i & ~req_oe_i;
endmodule // lss_far_model

//--- tb/lss_sequencer_tb.sv
// self-checking bench for the sideband sequencer
`timescale 1ns/1ns
`include "lss_defs.vh"
module lss_sequencer_tb;
    reg sys_clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    reg [11:0] paddr_i = 12'h000;
    reg [31:0] pwdata_i = 32'h0, rd, rnd = 32'hcf9689d5;
    reg [3:0] pstrb_i = 4'h0;
    reg host_reset_i = 0, host_power_good_i = 1, np_issue_i = 0, np_done_i = 0, er;
    reg supply_on = 0, reset_on = 1, stop_on = 0, req_on = 0;
    wire pready_o, pslverr_o, sup, rst_n, stp_n, req_n, sup_oe, rst_oe, stp_oe, req_oe;
    wire [31:0] prdata_o;
    wire sec_sup, sec_rst_n, np_error_o, link_reset_o, link_stop_o, hot_add_o;
    integer n_errors = 0, n_compared = 0, cyc = 0, npe;
    logic [31:0] ctrl_m = `LSS_CTRL_RESET_VAL, train_m = `LSS_TRAIN_RESET_VAL;
    lss_sequencer u_lss_sequencer (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pstrb_i(pstrb_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
        .supply_stable_in_i(sup), .supply_stable_out_o(), .supply_stable_oe_o(sup_oe),
        .chain_reset_n_i(rst_n), .chain_reset_n_out_o(), .chain_reset_n_oe_o(rst_oe),
        .link_stop_n_i(stp_n), .link_stop_n_out_o(), .link_stop_n_oe_o(stp_oe),
        .link_request_n_i(req_n), .link_request_n_out_o(), .link_request_n_oe_o(req_oe),
        .host_reset_i(host_reset_i), .host_power_good_i(host_power_good_i),
        .sec_supply_stable_o(sec_sup), .sec_chain_reset_n_o(sec_rst_n), .np_issue_i(np_issue_i),
        .np_done_i(np_done_i), .np_error_o(np_error_o), .link_reset_o(link_reset_o),
        .link_stop_o(link_stop_o), .hot_add_o(hot_add_o));
    lss_far_model u_lss_far_model (.sys_clk_i(sys_clk_i), .supply_on_i(supply_on),
        .reset_on_i(reset_on), .stop_on_i(stop_on), .req_on_i(req_on), .supply_oe_i(sup_oe),
        .reset_oe_i(rst_oe), .stop_oe_i(stp_oe), .req_oe_i(req_oe), .supply_o(sup),
        .reset_n_o(rst_n), .stop_n_o(stp_n), .req_n_o(req_n));
    initial begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function [31:0] xs(input [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction
    function [31:0] merge(input [31:0] o, input [31:0] d, input [3:0] s);
        for (int i = 0; i < 4; i++) begin
            if (s[i]) o[8*i +: 8] = d[8*i +: 8];
        end
        merge = o;
    endfunction
    task chk(input string what, input [31:0] seen, input [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
        @(posedge sys_clk_i);
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= s;
        @(posedge sys_clk_i);
        penable_i <= 1;
        do @(posedge sys_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
        if (w && a == `LSS_CTRL_OFF) ctrl_m = merge(ctrl_m, d, s);
        if (w && a == `LSS_TRAIN_OFF) train_m = merge(train_m, d, s);
    endtask
    task rchk(input string what, input [11:0] a, input [31:0] exp, input [31:0] m);
        apb(0, a, 0, 4'hf);
        chk(what, rd & m, exp & m);
    endtask
    task end_of_test;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        tick(16);
        rst_i <= 0;
        supply_on <= 1;
        reset_on <= 0;
        rchk("ctrl", `LSS_CTRL_OFF, ctrl_m, 32'hff);
        rchk("train", `LSS_TRAIN_OFF, train_m, 32'hff3f);
        chk("gen1 drive", {sup_oe, rst_oe}, 2'b11);
        rchk("unmapped", 12'h018, 0, 32'hffffffff);
        chk("unmapped err", er, 1);
        apb(1, `LSS_ID_OFF, 32'h0, 4'hf);
        rchk("id", `LSS_ID_OFF, `LSS_ID_VAL, 32'hffffffff);
        for (int i = 0; i < 6; i++) begin
            rnd = xs(rnd);
            apb(1, `LSS_TRAIN_OFF, rnd & 32'hffff_fffd, rnd[3:0]);
            rchk("train rnd", `LSS_TRAIN_OFF, train_m, 32'hff3f);
        end
        apb(1, `LSS_CTRL_OFF, 0, 4'hf);
        tick(60);
        chk("run", {link_reset_o, link_stop_o, hot_add_o}, 3'b000);
        rchk("stat run", `LSS_STAT_OFF, 32'h20f, 32'h70f);
        stop_on <= 1;
        tick(1);
        stop_on <= 0;
        tick(30);
        chk("stop", link_stop_o, 1);
        rchk("stat stop", `LSS_STAT_OFF, 32'h300, 32'h700);
        tick(100);
        chk("stop left", link_stop_o, 0);
        stop_on <= 1;
        tick(30);
        reset_on <= 1;
        tick(30);
        chk("reset wins", {link_reset_o, link_stop_o}, 2'b10);
        stop_on <= 0;
        reset_on <= 0;
        tick(150);
        chk("restart", link_reset_o, 0);
        apb(1, `LSS_CTRL_OFF, 32'h18, 4'h1);
        tick(30);
        chk("stop owner", {stp_oe, link_stop_o}, 2'b11);
        apb(1, `LSS_CTRL_OFF, 32'h20, 4'h1);
        tick(30);
        chk("request", {req_oe, req_n}, 2'b10);
        apb(1, `LSS_CTRL_OFF, 32'h40, 4'h1);
        tick(100);
        chk("sec pair", {sec_sup, sec_rst_n}, 2'b11);
        for (int i = 0; i < 4; i++) begin
            np_issue_i <= (i != 3);
            np_done_i <= (i == 3);
            tick(1);
        end
        np_done_i <= 0;
        rchk("np count", `LSS_NP_OFF, 2, 32'hff);
        reset_on <= 1;
        npe = 0;
        repeat (40) begin
            @(posedge sys_clk_i);
            if (np_error_o === 1'b1) npe++;
        end
        chk("np errors", npe, 2);
        chk("sec reset", sec_rst_n, 0);
        supply_on <= 0;
        tick(30);
        chk("sec supply", sec_sup, 0);
        supply_on <= 1;
        reset_on <= 0;
        apb(1, `LSS_CTRL_OFF, 32'h80, 4'h1);
        host_reset_i <= 1;
        host_power_good_i <= 0;
        tick(30);
        chk("host relay", {rst_oe, sup_oe}, 2'b11);
        host_reset_i <= 0;
        host_power_good_i <= 1;
        apb(1, `LSS_CTRL_OFF, 32'h7, 4'h1);
        tick(2);
        chk("gen3 no drive", {sup_oe, rst_oe}, 2'b00);
        apb(1, `LSS_TRAIN_OFF, 32'h1, 4'h1);
        reset_on <= 1;
        supply_on <= 0;
        tick(30);
        supply_on <= 1;
        tick(10100);
        reset_on <= 0;
        tick(60);
        chk("hot add", {hot_add_o, link_reset_o}, 2'b10);
        rchk("stat hot", `LSS_STAT_OFF, 32'h440, 32'h7c0);
        rchk("ctrl end", `LSS_CTRL_OFF, ctrl_m, 32'hff);
        end_of_test();
    end
endmodule // lss_sequencer_tb
